//--- rtl/swgc_top.sv
`timescale 1ns/10ps
module swgc_top
  import swgc_pkg::*;
#(
  parameter int unsigned PERIOD_A_CYCLES = PERIOD_A_CYC, // 16 ms window in cycles
  parameter int unsigned PERIOD_B_CYCLES = PERIOD_B_CYC, // 64 ms window in cycles
  parameter int unsigned PERIOD_C_CYCLES = PERIOD_C_CYC, // 256 ms window in cycles
  parameter logic [3:0] REV_ID = REV_DEFAULT // arbitrary revision code
) (
  input wire logic clk_i, // core clock, 50 MHz
  input wire logic nrst_i, // async reset, active low
  input wire logic [AXI_AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [AXI_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic umc_req_i, // unknown ip multicast frame to route
  input wire logic [NUM_PORTS-1:0] umc_default_map_i, // default forwarding map
  output logic umc_valid_o, // destination map ready
  output logic [NUM_PORTS-1:0] umc_map_o, // one bit per destination port
  input wire logic tos_req_i, // ip frame needs a priority
  input wire logic [7:0] tos_i, // tos / traffic class byte
  output logic prio_valid_o, // priority answer ready
  output logic prio_hit_o, // code point held in this bank
  output logic [1:0] prio_o, // frame priority
  input wire logic tag_req_i, // egress tag decision request
  input wire logic [2:0] src_port_i, // source port, 0 to 4
  input wire logic [NUM_PORTS-1:0] port_tag_ins_i, // per ingress port insert bit
  input wire logic [NUM_PORTS-1:0] src_tag_ins_i, // this egress, per source
  output logic tag_valid_o, // tag decision ready
  output logic tag_insert_o, // insert port_default_vlan_tag
  output logic egress_queue_mode_o, // 1 = per queue, 0 = per port
  output logic self_addr_filter_o, // self address filter enable
  output logic [1:0] ingress_period_o, // period code in use
  output logic ingress_tick_o // pulse at each window end
);

  ////////////////////////////////////////////////////////////////////////////
  // state of the bank and its lookup answers

  typedef struct packed {
    logic [7:0] mcast_ctrl;
    logic [7:0] rate_ctrl;
    logic [7:0] tos_map0;
    logic umc_valid;
    logic [NUM_PORTS-1:0] umc_map;
    logic prio_valid;
    logic prio_hit;
    logic [1:0] prio;
    logic tag_valid;
    logic tag_ins;
  } swgc_top_state_t;

  swgc_top_state_t s_q, s_d;

  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] rd_data;
  logic [5:0] code_pt;

  // masked write: only the listed bits change, reserved ones stay zero
  function automatic logic [7:0] merge_wr(input logic [7:0] old_v,
                                          input logic [7:0] new_v,
                                          input logic [7:0] wmask);
    merge_wr = (old_v & ~wmask) | (new_v & wmask);
  endfunction

  // priority for the four lowest code points, one field each
  function automatic logic [1:0] tos_field(input logic [7:0] map_v,
                                           input logic [1:0] sel);
    logic [1:0] f;
    f = map_v[1:0];
    unique case (sel)
      2'h3: f = map_v[7:6];
      2'h2: f = map_v[5:4];
      2'h1: f = map_v[3:2];
      2'h0: f = map_v[1:0];
    endcase
    tos_field = f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  swgc_axil_slave u_bus (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en_o(wr_en),
    .wr_idx_o(wr_idx),
    .wr_data_o(wr_data),
    .rd_idx_o(rd_idx),
    .rd_data_i(rd_data)
  );

  // read mux; unmapped indices read zero and the slave flags an error
  always_comb begin
    rd_data = 8'h00;
    if (rd_idx == IDX_MCAST_CTRL) begin
      rd_data = s_q.mcast_ctrl & MCAST_WMASK;
    end else if (rd_idx == IDX_RATE_TAG_CTRL) begin
      rd_data = s_q.rate_ctrl & RATE_WMASK;
    end else if (rd_idx == IDX_SILICON_REV) begin
      rd_data = {REV_ID, 4'h0};
    end else if (rd_idx == IDX_TOS_MAP_0) begin
      rd_data = s_q.tos_map0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ingress rate-limit window generator

  swgc_period_tick #(
    .CYC_A(CNT_W'(PERIOD_A_CYCLES)),
    .CYC_B(CNT_W'(PERIOD_B_CYCLES)),
    .CYC_C(CNT_W'(PERIOD_C_CYCLES))
  ) u_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .sel_i(ingress_period_o),
    .tick_o(ingress_tick_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // static control outputs straight from the registers

  assign ingress_period_o = s_q.rate_ctrl[RT_PERIOD_LSB +: 2];
  assign egress_queue_mode_o = s_q.rate_ctrl[RT_EGR_QUEUE_BIT];
  assign self_addr_filter_o = s_q.mcast_ctrl[MC_SELF_FILT_BIT];

  // code point: upper six bits of the tos byte
  assign code_pt = tos_i[7:TOS_CODE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // next state: register writes and the three lookups

  always_comb begin
    s_d = s_q;
    // register writes; the revision register has no storage at all
    if (wr_en) begin
      if (wr_idx == IDX_MCAST_CTRL) begin
        s_d.mcast_ctrl = merge_wr(s_q.mcast_ctrl, wr_data, MCAST_WMASK);
      end else if (wr_idx == IDX_RATE_TAG_CTRL) begin
        s_d.rate_ctrl = merge_wr(s_q.rate_ctrl, wr_data, RATE_WMASK);
      end else if (wr_idx == IDX_TOS_MAP_0) begin
        s_d.tos_map0 = merge_wr(s_q.tos_map0, wr_data, TOS_WMASK);
      end
    end

    // unknown ip multicast: map is a plain port mask, copies per set bit
    s_d.umc_valid = umc_req_i;
    if (umc_req_i) begin
      if (s_q.mcast_ctrl[MC_FWD_EN_BIT]) begin
        s_d.umc_map = s_q.mcast_ctrl[MC_MAP_LSB +: MC_MAP_W];
      end else begin
        s_d.umc_map = umc_default_map_i;
      end
    end

    // tos priority: only code points 0 to 3 live in this bank
    s_d.prio_valid = tos_req_i;
    if (tos_req_i) begin
      s_d.prio_hit = (code_pt[5:2] == 4'h0);
      s_d.prio = (code_pt[5:2] == 4'h0) ? tos_field(s_q.tos_map0, code_pt[1:0]) : 2'h0;
    end

    // egress vlan tag insertion policy
    s_d.tag_valid = tag_req_i;
    if (tag_req_i) begin
      if (src_port_i > 3'h4) begin
        s_d.tag_ins = 1'b0; // no such source port
      end else if (s_q.rate_ctrl[RT_TAG_SEL_BIT]) begin
        s_d.tag_ins = src_tag_ins_i[src_port_i];
      end else begin
        s_d.tag_ins = port_tag_ins_i[src_port_i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer outputs come from flip-flops

  assign umc_valid_o = s_q.umc_valid;
  assign umc_map_o = s_q.umc_map;
  assign prio_valid_o = s_q.prio_valid;
  assign prio_hit_o = s_q.prio_hit;
  assign prio_o = s_q.prio;
  assign tag_valid_o = s_q.tag_valid;
  assign tag_insert_o = s_q.tag_ins;

  // state register; reset values from the package
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.mcast_ctrl <= MCAST_RST;
      s_q.rate_ctrl <= RATE_RST;
      s_q.tos_map0 <= TOS_MAP_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- rtl/swgc_pkg.sv
package swgc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry: printed offsets are register indices, byte address = 4*idx
  localparam int AXI_AW = 12;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_MCAST_CTRL = 10'h086;
  localparam logic [IDX_W-1:0] IDX_RATE_TAG_CTRL = 10'h087;
  localparam logic [IDX_W-1:0] IDX_SILICON_REV = 10'h089;
  localparam logic [IDX_W-1:0] IDX_TOS_MAP_0 = 10'h090;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int MC_MAP_LSB = 0;
  localparam int MC_MAP_W = 5;
  localparam int MC_FWD_EN_BIT = 5;
  localparam int MC_SELF_FILT_BIT = 6;
  localparam int RT_TAG_SEL_BIT = 2;
  localparam int RT_EGR_QUEUE_BIT = 3;
  localparam int RT_PERIOD_LSB = 4;
  localparam int REV_LSB = 4;
  localparam int TOS_CODE_LSB = 2;
  localparam int NUM_PORTS = 5;

  // writable bits; everything else is reserved and reads zero
  localparam logic [7:0] MCAST_WMASK = 8'h7f;
  localparam logic [7:0] RATE_WMASK = 8'h3c;
  localparam logic [7:0] TOS_WMASK = 8'hff;

  // values after reset
  localparam logic [7:0] MCAST_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h10;
  localparam logic [7:0] TOS_MAP_RST = 8'h00;

  // arbitrary revision code, not tied to any real silicon
  localparam logic [3:0] REV_DEFAULT = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // ingress rate-limit windows
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PERIOD_A_MS = 16;
  localparam int unsigned PERIOD_B_MS = 64;
  localparam int unsigned PERIOD_C_MS = 256;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned PERIOD_A_CYC = PERIOD_A_MS * CYC_PER_MS;
  localparam int unsigned PERIOD_B_CYC = PERIOD_B_MS * CYC_PER_MS;
  localparam int unsigned PERIOD_C_CYC = PERIOD_C_MS * CYC_PER_MS;
  localparam int CNT_W = 24;
  localparam logic [1:0] PERIOD_SEL_A = 2'h0;
  localparam logic [1:0] PERIOD_SEL_B = 2'h1;

  // true for every register index this bank answers
  function automatic logic reg_mapped(input logic [IDX_W-1:0] idx);
    reg_mapped = (idx == IDX_MCAST_CTRL) || (idx == IDX_RATE_TAG_CTRL) ||
                 (idx == IDX_SILICON_REV) || (idx == IDX_TOS_MAP_0);
  endfunction

endpackage

//--- rtl/swgc_axil_slave.sv
`timescale 1ns/10ps
module swgc_axil_slave
  import swgc_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic nrst_i, // async reset, active low
  input wire logic [AXI_AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [AXI_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic wr_en_o, // one-cycle register write
  output logic [IDX_W-1:0] wr_idx_o, // register index written
  output logic [7:0] wr_data_o, // low byte written
  output logic [IDX_W-1:0] rd_idx_o, // register index read
  input wire logic [7:0] rd_data_i // read value for rd_idx_o
);

  typedef struct packed {
    logic aw_have;
    logic [IDX_W-1:0] aw_idx;
    logic aw_ok;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } swgc_axil_state_t;

  swgc_axil_state_t s_q, s_d;

  ////////////////////////////////////////////////////////////////////////////
  // channel readies: one write and one read in flight at most
  assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_have && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = {24'h000000, s_q.rdata};
  assign rd_idx_o = s_axi_araddr[IDX_W+1:2];
  // write fires once both halves are held; a lane-0-less write stores nothing
  assign wr_en_o = s_q.aw_have && s_q.w_have && s_q.aw_ok && s_q.w_lane0;
  assign wr_idx_o = s_q.aw_idx;
  assign wr_data_o = s_q.w_data;

  // next state
  always_comb begin
    s_d = s_q;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_idx = s_axi_awaddr[IDX_W+1:2];
      s_d.aw_ok = reg_mapped(s_axi_awaddr[IDX_W+1:2]);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_q.aw_have && s_q.w_have) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = s_q.aw_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_data_i;
      s_d.rresp = reg_mapped(rd_idx_o) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- rtl/swgc_period_tick.sv
`timescale 1ns/10ps
module swgc_period_tick
  import swgc_pkg::*;
#(
  parameter logic [CNT_W-1:0] CYC_A = CNT_W'(PERIOD_A_CYC), // window for code 00
  parameter logic [CNT_W-1:0] CYC_B = CNT_W'(PERIOD_B_CYC), // window for code 01
  parameter logic [CNT_W-1:0] CYC_C = CNT_W'(PERIOD_C_CYC) // window for code 1x
) (
  input wire logic clk_i, // core clock
  input wire logic nrst_i, // async reset, active low
  input wire logic [1:0] sel_i, // period code
  output logic tick_o // one-cycle pulse at window end
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [1:0] sel;
    logic tick;
  } swgc_tick_state_t;

  swgc_tick_state_t s_q, s_d;
  logic [CNT_W-1:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // window length; any code with the upper bit set is the long window
  always_comb begin
    if (sel_i == PERIOD_SEL_A) begin
      limit = CYC_A;
    end else if (sel_i == PERIOD_SEL_B) begin
      limit = CYC_B;
    end else begin
      limit = CYC_C;
    end
  end

  // a new code restarts the window so no stale partial count leaks across
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.sel = sel_i;
    if (sel_i != s_q.sel) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= limit - CNT_W'(1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
    end
  end

  assign tick_o = s_q.tick;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= {{CNT_W{1'b0}}, PERIOD_SEL_B, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- tb/swgc_monitor.sv
`timescale 1ns/10ps
module swgc_monitor
  import swgc_pkg::*;
#(
  parameter logic [3:0] REV_ID = REV_DEFAULT // revision code on reads
) (
  input wire logic clk_i, // core clock
  input wire logic nrst_i, // reset, active low
  input wire logic [AXI_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // read data valid
  input wire logic umc_req_i, // multicast lookup request
  input wire logic umc_valid_o, // multicast answer
  input wire logic [NUM_PORTS-1:0] umc_map_o, // destination map
  input wire logic tos_req_i, // priority lookup request
  input wire logic [7:0] tos_i, // tos byte
  input wire logic prio_valid_o, // priority answer
  input wire logic prio_hit_o, // code point held here
  input wire logic [1:0] prio_o, // frame priority
  input wire logic tag_req_i, // tag decision request
  input wire logic [2:0] src_port_i, // source port
  input wire logic [NUM_PORTS-1:0] port_tag_ins_i, // per ingress insert bit
  input wire logic [NUM_PORTS-1:0] src_tag_ins_i, // per source option
  input wire logic tag_valid_o, // tag answer
  input wire logic tag_insert_o, // insert decision
  input wire logic ingress_tick_o // window end pulse
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////////
  // insert bit of the requested source, kept for the answer cycle
  logic tag_exp_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tag_exp_q <= 1'b0;
    end else begin
      tag_exp_q <= port_tag_ins_i[src_port_i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads
  sequence s_rev_take;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h224;
  endsequence
  chk_rev_read: assert property (s_rev_take |=> s_axi_rvalid && s_axi_rdata == {24'h0, REV_ID, 4'h0})
    else $error("revision read wrong");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // lookups answer one cycle after the request
  chk_prio_hit: assert property (tos_req_i && tos_i[7:2] < 6'h4 |=> prio_valid_o && prio_hit_o)
    else $error("low code point missed");
  chk_prio_miss: assert property (tos_req_i && tos_i[7:2] > 6'h3 |=> prio_valid_o && !prio_hit_o && prio_o == 2'h0)
    else $error("high code point hit");
  // where both options agree the select bit cannot matter
  chk_tag_agree: assert property (tag_req_i && src_port_i < 3'h5 && port_tag_ins_i[src_port_i] == src_tag_ins_i[src_port_i] |=> tag_valid_o && tag_insert_o == tag_exp_q)
    else $error("tag decision wrong");
  chk_umc_answer: assert property (umc_req_i |=> umc_valid_o)
    else $error("multicast answer missing");
  chk_umc_hold: assert property (!umc_req_i |=> !umc_valid_o && $stable(umc_map_o))
    else $error("multicast map moved unasked");
  // shortest window is far longer than eight cycles
  chk_tick_gap: assert property (ingress_tick_o |=> !ingress_tick_o [*8])
    else $error("window ticks too close");
endmodule

bind swgc_top swgc_monitor #(.REV_ID(REV_ID)) i_swgc_monitor (.clk_i, .nrst_i, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .umc_req_i, .umc_valid_o,
  .umc_map_o, .tos_req_i, .tos_i, .prio_valid_o, .prio_hit_o, .prio_o, .tag_req_i, .src_port_i,
  .port_tag_ins_i, .src_tag_ins_i, .tag_valid_o, .tag_insert_o, .ingress_tick_o);

//--- tb/swgc_tb.sv
`timescale 1ns/10ps
module testbench
  import swgc_pkg::*;
;
  localparam logic [3:0] REV = 4'h9; // arbitrary revision code
  localparam logic [11:0] AD [4] = '{12'h218, 12'h21c, 12'h224, 12'h240};
  localparam logic [7:0] RV [4] = '{8'h00, 8'h10, {REV, 4'h0}, 8'h00};
  localparam logic [7:0] MK [4] = '{8'h7f, 8'h3c, 8'h00, 8'hff};
  localparam logic [4:0] MP [5] = '{5'h00, 5'h01, 5'h03, 5'h02, 5'h1f};
  localparam logic [7:0] PAT [2] = '{8'h1b, 8'he4};
  localparam int LIM [4] = '{16, 64, 256, 256};
  logic clk_i, nrst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, prio_o, ingress_period_o;
  logic umc_req_i, umc_valid_o, tos_req_i, prio_valid_o, prio_hit_o, tag_req_i, tag_valid_o;
  logic tag_insert_o, egress_queue_mode_o, self_addr_filter_o, ingress_tick_o;
  logic [4:0] umc_default_map_i, umc_map_o, port_tag_ins_i, src_tag_ins_i;
  logic [7:0] tos_i;
  logic [2:0] src_port_i;
  int n_fail, compares;

  // short windows keep the run brief
  swgc_top #(.PERIOD_A_CYCLES(16), .PERIOD_B_CYCLES(64), .PERIOD_C_CYCLES(256), .REV_ID(REV))
    i_swgc_top (.clk_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .umc_req_i, .umc_default_map_i, .umc_valid_o, .umc_map_o, .tos_req_i, .tos_i,
    .prio_valid_o, .prio_hit_o, .prio_o, .tag_req_i, .src_port_i, .port_tag_ins_i,
    .src_tag_ins_i, .tag_valid_o, .tag_insert_o, .egress_queue_mode_o, .self_addr_filter_o,
    .ingress_period_o, .ingress_tick_o);

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #200us;
    n_fail++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // handshake values are read at the negedge, when readies have settled
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic al, wl, ah, wh;
    int k;
    al = 1'b1;
    wl = 1'b1;
    k = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while ((al || wl) && k < 40) begin
      @(negedge clk_i);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      k++;
      @(posedge clk_i);
      if (ah) begin
        s_axi_awvalid <= 1'b0;
        al = 1'b0;
      end
      if (wh) begin
        s_axi_wvalid <= 1'b0;
        wl = 1'b0;
      end
    end
    do begin
      @(negedge clk_i);
      k++;
    end while (!s_axi_bvalid && k < 80);
    cmp(32'(s_axi_bresp), 32'(er));
    @(posedge clk_i);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge clk_i);
      k++;
    end while (!s_axi_arready && k < 40);
    @(posedge clk_i);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk_i);
      k++;
    end while (!s_axi_rvalid && k < 80);
    cmp(s_axi_rdata, ed);
    cmp(32'(s_axi_rresp), 32'(er));
    @(posedge clk_i);
    s_axi_rready <= 1'b0;
  endtask

  // one-cycle lookup request; returns in the answer cycle
  task automatic look(input logic [2:0] q, input logic [4:0] m, input logic [7:0] t,
                      input logic [2:0] s);
    @(posedge clk_i);
    {tag_req_i, tos_req_i, umc_req_i} <= q;
    umc_default_map_i <= m;
    tos_i <= t;
    src_port_i <= s;
    @(posedge clk_i);
    {tag_req_i, tos_req_i, umc_req_i} <= 3'h0;
    @(negedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int i, j, k;
    logic h;
    logic [1:0] p;
    n_fail = 0;
    compares = 0;
    {nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {umc_req_i, tos_req_i, tag_req_i, umc_default_map_i, tos_i, src_port_i} = '0;
    port_tag_ins_i = 5'h15;
    src_tag_ins_i = 5'h16;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (i = 0; i < 4; i++) begin
      rd(AD[i], {24'h0, RV[i]}, RESP_OKAY);
      wr(AD[i], 32'hffffffff, 4'hf, RESP_OKAY);
      rd(AD[i], {24'h0, RV[i] | MK[i]}, RESP_OKAY);
    end
    // unmapped place, and a write with its byte lane off
    cmp(32'(self_addr_filter_o), 32'h1);
    wr(12'h400, 32'hff, 4'hf, RESP_SLVERR);
    rd(12'h400, 32'h0, RESP_SLVERR);
    wr(12'h240, 32'h0, 4'h0, RESP_OKAY);
    rd(12'h240, 32'hff, RESP_OKAY);
    // map ignored while its enable is clear
    wr(12'h218, 32'h03, 4'h1, RESP_OKAY);
    cmp(32'(self_addr_filter_o), 32'h0);
    look(3'h1, 5'h15, 8'h0, 3'h0);
    cmp(32'({umc_valid_o, umc_map_o}), 32'h35);
    for (i = 0; i < 5; i++) begin
      wr(12'h218, 32'(MP[i]) | 32'h20, 4'h1, RESP_OKAY);
      look(3'h1, 5'h0a, 8'h0, 3'h0);
      cmp(32'({umc_valid_o, umc_map_o}), 32'({1'b1, MP[i]}));
    end
    // code points 0..3 each own a field, 4 is not held here
    for (j = 0; j < 2; j++) begin
      wr(12'h240, 32'(PAT[j]), 4'h1, RESP_OKAY);
      for (i = 0; i < 5; i++) begin
        h = (i < 4);
        p = h ? PAT[j][2*i +: 2] : 2'h0;
        look(3'h2, 5'h0, 8'(i * 4 + 1), 3'h0);
        cmp(32'({prio_valid_o, prio_hit_o, prio_o}), 32'({1'b1, h, p}));
      end
    end
    for (j = 0; j < 2; j++) begin
      wr(12'h21c, 32'h10 | 32'(j * 4), 4'h1, RESP_OKAY);
      for (i = 0; i < 5; i++) begin
        h = j ? src_tag_ins_i[i] : port_tag_ins_i[i];
        look(3'h4, 5'h0, 8'h0, 3'(i));
        cmp(32'({tag_valid_o, tag_insert_o}), 32'({1'b1, h}));
      end
    end
    wr(12'h21c, 32'h18, 4'h1, RESP_OKAY);
    cmp(32'(egress_queue_mode_o), 32'h1);
    // window length for every period code
    for (i = 0; i < 4; i++) begin
      wr(12'h21c, 32'(i * 16), 4'h1, RESP_OKAY);
      cmp(32'({egress_queue_mode_o, ingress_period_o}), 32'(i));
      k = 0;
      do begin
        @(negedge clk_i);
        k++;
      end while (!ingress_tick_o && k < 600);
      k = 0;
      do begin
        @(negedge clk_i);
        k++;
      end while (!ingress_tick_o && k < 600);
      cmp(32'(k), 32'(LIM[i]));
    end
    wrap_up();
  end
endmodule
